// ---- dtu_map.vh ----
// dtu_map.vh: named constants of the data-transfer instruction unit.
// assumes: included by bare name from the memory and core design files of the unit.
`ifndef DTU_MAP_VH
`define DTU_MAP_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define DTU_OP_W          4
`define DTU_OP_MOV_A_I    4'h0
`define DTU_OP_MOV_M_A    4'h1
`define DTU_OP_MOV_A_M    4'h2
`define DTU_OP_MOV_A_IO   4'h3
`define DTU_OP_MOV_IO_A   4'h4
`define DTU_OP_T2W        4'h5
`define DTU_OP_W2T        4'h6
`define DTU_OP_IDX_LD     4'h7
`define DTU_OP_IDX_ST     4'h8
`define DTU_OP_ADD_A_I    4'h9
`define DTU_OP_SUB_A_I    4'hA
`define DTU_OP_ADD_A_M    4'hB
`define DTU_OP_SUB_A_M    4'hC
`define DTU_OP_BSET_M     4'hD
`define DTU_OP_BCLR_M     4'hE
`define DTU_OP_LAST       4'hE

// ----------------------------------------------------------------
// limits, widths and reset values
// ----------------------------------------------------------------
`define DTU_BIT_ADDR_MAX  8'h3F
`define DTU_RAM_DEPTH     256
`define DTU_ACC_RST       8'h00
`define DTU_BYTE_ZERO     8'h00
`define DTU_BYTE_ONE      8'h01
`define DTU_WORD_ZERO     16'h0000
`define DTU_FLAG_RST      1'b0

`endif

// ---- dtu_flags.v ----
// dtu_flags.v: 8-bit add/subtract with carry, half carry and signed range.
// assumes: purely combinational, operands stable while sampled.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// alu for flag-updating instructions
// ----------------------------------------------------------------
module dtu_flags
(
    input  wire [7:0] op_a,
    input  wire [7:0] op_b,
    input  wire       do_sub,
    output reg  [7:0] result,
    output reg        carry,
    output reg        half_carry,
    output reg        signed_range
);

    reg [8:0] full_sum;
    reg [4:0] nib_sum;

    // subtraction reports borrows in the carry positions
    always @*
    begin
        full_sum = 9'h000;
        nib_sum  = 5'h00;
        if (do_sub)
        begin
            full_sum = {1'b0, op_a} - {1'b0, op_b};
            nib_sum  = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]};
        end
        else
        begin
            full_sum = {1'b0, op_a} + {1'b0, op_b};
            nib_sum  = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
        end
        result       = full_sum[7:0];
        carry        = full_sum[8];
        half_carry   = nib_sum[4];
        // overflow: operand signs agree (add) or differ (sub) vs result
        if (do_sub)
            signed_range = (op_a[7] ^ op_b[7]) & (full_sum[7] ^ op_a[7]);
        else
            signed_range = ~(op_a[7] ^ op_b[7]) & (full_sum[7] ^ op_a[7]);
    end

endmodule // dtu_flags

// ---- dtu_ram.v ----
// dtu_ram.v: data memory, one synchronous write port, two async reads.
// assumes: single clock; contents are undefined until written.
`timescale 1ns/1ps
`include "dtu_map.vh"

// ----------------------------------------------------------------
// byte memory with word read
// ----------------------------------------------------------------
module dtu_ram
(
    input  wire       clk,
    input  wire       wr_en,
    input  wire [7:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire [7:0] rd_addr_lo,
    input  wire [7:0] rd_addr_hi,
    output wire [7:0] rd_data_lo,
    output wire [7:0] rd_data_hi
);

    reg [7:0] mem [0:`DTU_RAM_DEPTH-1];

    // no reset on the array: software initialises what it uses
    always @(posedge clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
    end

    // two read ports so a whole word is seen in one cycle
    assign rd_data_lo = mem[rd_addr_lo];
    assign rd_data_hi = mem[rd_addr_hi];

endmodule // dtu_ram

// ---- dtu_core.v ----
// dtu_core.v: data-transfer instruction unit with accumulator and flags.
// assumes: io register file and timer run on clk and answer in the same
// cycle; one command at a time through a valid/ready handshake.
`timescale 1ns/1ps
`include "dtu_map.vh"

module dtu_core
(
    input  wire        clk,
    input  wire        rst,
    input  wire        cmd_valid,
    input  wire [3:0]  cmd_op,
    input  wire [7:0]  cmd_addr,
    input  wire [7:0]  cmd_imm,
    output wire        cmd_ready,
    output wire        cmd_done,
    output wire        cmd_err,
    output wire [7:0]  acc_out,
    output wire        zero_flag,
    output wire        carry_flag,
    output wire        half_carry_flag,
    output wire        signed_range_flag,
    output wire [7:0]  io_addr,
    output wire [7:0]  io_wdata,
    output wire        io_we,
    output wire        io_re,
    input  wire [7:0]  io_rdata,
    input  wire [15:0] timer_count,
    output wire        timer_load,
    output wire [15:0] timer_load_value
);

    // ----------------------------------------------------------------
    // sequencer states, one instruction cycle is two clocks
    // ----------------------------------------------------------------
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_T1A  = 5'b00010;
    localparam [4:0] S_T1B  = 5'b00100;
    localparam [4:0] S_T2A  = 5'b01000;
    localparam [4:0] S_T2B  = 5'b10000;

    reg [4:0]  state_reg;
    reg [3:0]  op_reg;
    reg [7:0]  addr_reg;
    reg [7:0]  imm_reg;
    reg [7:0]  ptr_reg;
    reg [7:0]  hi_hold_reg;
    reg [7:0]  acc_reg;
    reg        zero_reg;
    reg        carry_reg;
    reg        half_carry_reg;
    reg        signed_range_reg;
    reg        ready_reg;
    reg        done_reg;
    reg        err_reg;
    reg [7:0]  io_addr_reg;
    reg [7:0]  io_wdata_reg;
    reg        io_we_reg;
    reg        io_re_reg;
    reg        timer_load_reg;
    reg [15:0] timer_value_reg;

    reg        ram_we;
    reg [7:0]  ram_waddr;
    reg [7:0]  ram_wdata;
    wire [7:0] ram_raddr_lo;
    wire [7:0] ram_raddr_hi;
    wire [7:0] ram_rdata_lo;
    wire [7:0] ram_rdata_hi;

    wire [7:0] alu_b;
    wire       alu_sub;
    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_ac;
    wire       alu_ov;
    wire [7:0] bit_mask;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function is_zero;
        input [7:0] value;
        begin
            is_zero = (value == `DTU_BYTE_ZERO);
        end
    endfunction

    function is_bit_op;
        input [3:0] op;
        begin
            is_bit_op = (op == `DTU_OP_BSET_M) || (op == `DTU_OP_BCLR_M);
        end
    endfunction

    function is_indirect;
        input [3:0] op;
        begin
            is_indirect = (op == `DTU_OP_IDX_LD) || (op == `DTU_OP_IDX_ST);
        end
    endfunction

    function cmd_refused;
        input [3:0] op;
        input [7:0] addr;
        begin
            // bit operations beyond the bit-addressable window are refused
            cmd_refused = (op > `DTU_OP_LAST) ||
                          (is_bit_op(op) && (addr > `DTU_BIT_ADDR_MAX));
        end
    endfunction

    // ----------------------------------------------------------------
    // datapath instances
    // ----------------------------------------------------------------
    // the pointer low byte alone addresses memory in the second cycle
    assign ram_raddr_lo = (state_reg == S_T2A) ? ptr_reg : addr_reg;
    assign ram_raddr_hi = addr_reg + `DTU_BYTE_ONE;

    dtu_ram u_ram
    (
        .clk        (clk),
        .wr_en      (ram_we),
        .wr_addr    (ram_waddr),
        .wr_data    (ram_wdata),
        .rd_addr_lo (ram_raddr_lo),
        .rd_addr_hi (ram_raddr_hi),
        .rd_data_lo (ram_rdata_lo),
        .rd_data_hi (ram_rdata_hi)
    );

    assign alu_b   = ((op_reg == `DTU_OP_ADD_A_M) ||
                      (op_reg == `DTU_OP_SUB_A_M)) ? ram_rdata_lo : imm_reg;
    assign alu_sub = (op_reg == `DTU_OP_SUB_A_I) ||
                     (op_reg == `DTU_OP_SUB_A_M);

    dtu_flags u_flags
    (
        .op_a         (acc_reg),
        .op_b         (alu_b),
        .do_sub       (alu_sub),
        .result       (alu_res),
        .carry        (alu_c),
        .half_carry   (alu_ac),
        .signed_range (alu_ov)
    );

    assign bit_mask = `DTU_BYTE_ONE << imm_reg[2:0];

    // ----------------------------------------------------------------
    // memory write port
    // ----------------------------------------------------------------
    // writes happen only in the A half of an instruction cycle, except
    // the high byte of a timer snapshot which follows one clock later
    always @*
    begin
        ram_we    = 1'b0;
        ram_waddr = addr_reg;
        ram_wdata = acc_reg;
        if (state_reg == S_T1A)
        begin
            case (op_reg)
                `DTU_OP_MOV_M_A:
                begin
                    ram_we = 1'b1;
                end
                `DTU_OP_T2W:
                begin
                    ram_we    = 1'b1;
                    ram_wdata = timer_count[7:0];
                end
                `DTU_OP_BSET_M:
                begin
                    ram_we    = 1'b1;
                    ram_wdata = ram_rdata_lo | bit_mask;
                end
                `DTU_OP_BCLR_M:
                begin
                    ram_we    = 1'b1;
                    ram_wdata = ram_rdata_lo & ~bit_mask;
                end
                default:
                begin
                    ram_we = 1'b0;
                end
            endcase
        end
        else if ((state_reg == S_T1B) && (op_reg == `DTU_OP_T2W))
        begin
            ram_we    = 1'b1;
            ram_waddr = ram_raddr_hi;
            ram_wdata = hi_hold_reg;
        end
        else if ((state_reg == S_T2A) && (op_reg == `DTU_OP_IDX_ST))
        begin
            ram_we    = 1'b1;
            ram_waddr = ptr_reg;
        end
    end

    // ----------------------------------------------------------------
    // sequencer, accumulator and flags
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg        <= S_IDLE;
            op_reg           <= `DTU_OP_MOV_A_I;
            addr_reg         <= `DTU_BYTE_ZERO;
            imm_reg          <= `DTU_BYTE_ZERO;
            ptr_reg          <= `DTU_BYTE_ZERO;
            hi_hold_reg      <= `DTU_BYTE_ZERO;
            acc_reg          <= `DTU_ACC_RST;
            zero_reg         <= `DTU_FLAG_RST;
            carry_reg        <= `DTU_FLAG_RST;
            half_carry_reg   <= `DTU_FLAG_RST;
            signed_range_reg <= `DTU_FLAG_RST;
            ready_reg        <= 1'b1;
            done_reg         <= 1'b0;
            err_reg          <= 1'b0;
            io_addr_reg      <= `DTU_BYTE_ZERO;
            io_wdata_reg     <= `DTU_BYTE_ZERO;
            io_we_reg        <= 1'b0;
            io_re_reg        <= 1'b0;
            timer_load_reg   <= 1'b0;
            timer_value_reg  <= `DTU_WORD_ZERO;
        end
        else
        begin
            // strobes are one-clock pulses unless set below
            done_reg       <= 1'b0;
            err_reg        <= 1'b0;
            io_we_reg      <= 1'b0;
            io_re_reg      <= 1'b0;
            timer_load_reg <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        op_reg   <= cmd_op;
                        addr_reg <= cmd_addr;
                        imm_reg  <= cmd_imm;
                        if (cmd_refused(cmd_op, cmd_addr))
                        begin
                            // refused: no side effect, answered at once
                            done_reg <= 1'b1;
                            err_reg  <= 1'b1;
                        end
                        else
                        begin
                            ready_reg <= 1'b0;
                            state_reg <= S_T1A;
                            if (cmd_op == `DTU_OP_MOV_A_IO)
                            begin
                                io_re_reg   <= 1'b1;
                                io_addr_reg <= cmd_addr;
                            end
                            if (cmd_op == `DTU_OP_MOV_IO_A)
                            begin
                                io_we_reg    <= 1'b1;
                                io_addr_reg  <= cmd_addr;
                                io_wdata_reg <= acc_reg;
                            end
                        end
                    end
                end
                S_T1A:
                begin
                    state_reg <= S_T1B;
                    case (op_reg)
                        `DTU_OP_MOV_A_I:
                        begin
                            acc_reg <= imm_reg;
                        end
                        `DTU_OP_MOV_A_M:
                        begin
                            acc_reg  <= ram_rdata_lo;
                            zero_reg <= is_zero(ram_rdata_lo);
                        end
                        `DTU_OP_MOV_A_IO:
                        begin
                            acc_reg  <= io_rdata;
                            zero_reg <= is_zero(io_rdata);
                        end
                        `DTU_OP_T2W:
                        begin
                            // hold the high byte so the word is one snapshot
                            hi_hold_reg <= timer_count[15:8];
                        end
                        `DTU_OP_W2T:
                        begin
                            timer_load_reg  <= 1'b1;
                            timer_value_reg <= {ram_rdata_hi, ram_rdata_lo};
                        end
                        `DTU_OP_IDX_LD,
                        `DTU_OP_IDX_ST:
                        begin
                            // high pointer byte is ignored, software zeroes it
                            ptr_reg <= ram_rdata_lo;
                        end
                        `DTU_OP_ADD_A_I,
                        `DTU_OP_SUB_A_I,
                        `DTU_OP_ADD_A_M,
                        `DTU_OP_SUB_A_M:
                        begin
                            acc_reg          <= alu_res;
                            zero_reg         <= is_zero(alu_res);
                            carry_reg        <= alu_c;
                            half_carry_reg   <= alu_ac;
                            signed_range_reg <= alu_ov;
                        end
                        default:
                        begin
                            acc_reg <= acc_reg;
                        end
                    endcase
                end
                S_T1B:
                begin
                    if (is_indirect(op_reg))
                        state_reg <= S_T2A;
                    else
                    begin
                        state_reg <= S_IDLE;
                        ready_reg <= 1'b1;
                        done_reg  <= 1'b1;
                    end
                end
                S_T2A:
                begin
                    state_reg <= S_T2B;
                    if (op_reg == `DTU_OP_IDX_LD)
                        acc_reg <= ram_rdata_lo;
                end
                S_T2B:
                begin
                    state_reg <= S_IDLE;
                    ready_reg <= 1'b1;
                    done_reg  <= 1'b1;
                end
                default:
                begin
                    state_reg <= S_IDLE;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign cmd_ready         = ready_reg;
    assign cmd_done          = done_reg;
    assign cmd_err           = err_reg;
    assign acc_out           = acc_reg;
    assign zero_flag         = zero_reg;
    assign carry_flag        = carry_reg;
    assign half_carry_flag   = half_carry_reg;
    assign signed_range_flag = signed_range_reg;
    assign io_addr           = io_addr_reg;
    assign io_wdata          = io_wdata_reg;
    assign io_we             = io_we_reg;
    assign io_re             = io_re_reg;
    assign timer_load        = timer_load_reg;
    assign timer_load_value  = timer_value_reg;

endmodule // dtu_core

// ---- dtu_core_monitor.sv ----
// dtu_core_monitor.sv: concurrent checks on the instruction unit ports.
// assumes: bound to dtu_core, one clock, rst asynchronous and active high.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module dtu_check
(
    input wire        clk,
    input wire        rst,
    input wire        cmd_valid,
    input wire [3:0]  cmd_op,
    input wire [7:0]  cmd_addr,
    input wire [7:0]  cmd_imm,
    input wire        cmd_ready,
    input wire        cmd_done,
    input wire        cmd_err,
    input wire [7:0]  acc_out,
    input wire        zero_flag,
    input wire        carry_flag,
    input wire        half_carry_flag,
    input wire        signed_range_flag,
    input wire [7:0]  io_addr,
    input wire [7:0]  io_wdata,
    input wire        io_we,
    input wire        io_re,
    input wire [7:0]  io_rdata,
    input wire        timer_load
);
    // accepted command, flag view and reference arithmetic of this cycle
    wire       take = cmd_valid && cmd_ready;
    wire [3:0] flg  = {zero_flag, carry_flag, half_carry_flag,
                       signed_range_flag};
    wire       keep = (cmd_op == 4'h0) || (cmd_op == 4'h1) ||
                      (cmd_op >= 4'h4 && cmd_op <= 4'h6);
    wire       two  = (cmd_op == 4'h7) || (cmd_op == 4'h8);
    wire [8:0] sum  = {1'b0, acc_out} + {1'b0, cmd_imm};
    wire [8:0] dif  = {1'b0, acc_out} - {1'b0, cmd_imm};
    wire [4:0] nib  = {1'b0, acc_out[3:0]} + {1'b0, cmd_imm[3:0]};
    wire       hcy  = nib[4];
    wire       ovf  = (acc_out[7] == cmd_imm[7]) && (sum[7] != acc_out[7]);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    imm_load_a: assert property (
        take && cmd_op == 4'h0 |-> ##2 acc_out == $past(cmd_imm, 2))
        else $error("immediate not in accumulator");
    plain_flags_a: assert property (
        take && keep |=> $stable(flg) [*3])
        else $error("flags moved on a plain transfer");
    load_flags_a: assert property (
        take && !two && cmd_op <= 4'h6 |=> $stable(flg[2:0]) [*3])
        else $error("carry group moved on a load");
    zero_load_a: assert property (
        take && (cmd_op == 4'h2 || cmd_op == 4'h3)
        |-> ##2 zero_flag == (acc_out == 8'h00))
        else $error("zero flag wrong after load");
    add_flags_a: assert property (
        take && cmd_op == 4'h9 |-> ##2 {carry_flag, acc_out} == $past(sum, 2)
        && half_carry_flag == $past(hcy, 2)
        && signed_range_flag == $past(ovf, 2)
        && zero_flag == (acc_out == 8'h00))
        else $error("add result or flags wrong");
    sub_borrow_a: assert property (
        take && cmd_op == 4'hA |-> ##2 {carry_flag, acc_out} == $past(dif, 2))
        else $error("subtract borrow wrong");
    io_write_a: assert property (
        take && cmd_op == 4'h4 |=> io_we && io_wdata == $past(acc_out)
        && io_addr == $past(cmd_addr))
        else $error("io write strobe or data wrong");
    io_read_a: assert property (
        take && cmd_op == 4'h3 |=> io_re && io_addr == $past(cmd_addr)
        ##1 acc_out == $past(io_rdata))
        else $error("io read not copied");
    timer_pulse_a: assert property (
        take && cmd_op == 4'h6 |-> ##2 timer_load ##1 !timer_load)
        else $error("timer load pulse misplaced");
    two_cycle_a: assert property (
        take && two |=> !cmd_done [*4] ##1 cmd_done)
        else $error("indirect move length wrong");
    indirect_flags_a: assert property (
        take && two |=> $stable(flg) [*5])
        else $error("flags moved on indirect move");
    bit_refuse_a: assert property (
        take && (cmd_op == 4'hD || cmd_op == 4'hE) && cmd_addr > 8'h3F
        |=> cmd_done && cmd_err && cmd_ready && $stable(flg))
        else $error("bit access above limit not refused");
endmodule // dtu_check

bind dtu_core dtu_check u_check
(
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_imm(cmd_imm), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_err(cmd_err), .acc_out(acc_out),
    .zero_flag(zero_flag), .carry_flag(carry_flag),
    .half_carry_flag(half_carry_flag), .signed_range_flag(signed_range_flag),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
    .io_rdata(io_rdata), .timer_load(timer_load)
);

// ---- dtu_far.sv ----
// dtu_far.sv: io register file and sixteen-bit timer beside the unit.
// assumes: same clock as dtu_core; io answer is combinational.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// far side model
// ----------------------------------------------------------------
module dtu_far
(
    input  wire        clk,
    input  wire [7:0]  io_addr,
    input  wire [7:0]  io_wdata,
    input  wire        io_we,
    input  wire        io_re,
    output wire [7:0]  io_rdata,
    output reg  [15:0] timer_count,
    input  wire        timer_load,
    input  wire [15:0] timer_load_value
);
    reg [7:0] io_reg [0:255];
    integer   i;

    // unwritten registers hold a per-address pattern, never a copy
    initial
    begin
        for (i = 0; i < 256; i = i + 1)
            io_reg[i] = i[7:0] ^ 8'h5A;
        timer_count = 16'h0000;
    end

    // outside the read strobe the answer is inverted, so late sampling shows
    assign io_rdata = io_re ? io_reg[io_addr] : ~io_reg[io_addr];

    // register writes and timer load; timer is frozen to keep counts exact
    always @(posedge clk)
    begin
        if (io_we)
            io_reg[io_addr] <= io_wdata;
        if (timer_load)
            timer_count <= timer_load_value;
    end
endmodule // dtu_far

// ---- dtu_core_bench.sv ----
// dtu_core_bench.sv: command-level self-checking bench for dtu_core.
// assumes: dtu_core, dtu_far and the bound checker are compiled first.
`timescale 1ns/1ps

`define CHK(g, e) \
    begin \
        checked = checked + 1; \
        if ((g) !== (e)) \
        begin \
            err_count = err_count + 1; \
            $display("unexpected at %0t: got %h want %h", $time, g, e); \
        end \
    end

module dtu_core_bench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         cmd_valid = 1'b0;
    reg  [3:0]  cmd_op = 4'h0;
    reg  [7:0]  cmd_addr = 8'h00;
    reg  [7:0]  cmd_imm = 8'h00;
    wire        cmd_ready, cmd_done, cmd_err, io_we, io_re, timer_load;
    wire        zero_flag, carry_flag, half_carry_flag, signed_range_flag;
    wire [7:0]  acc_out, io_addr, io_wdata, io_rdata;
    wire [15:0] timer_count, timer_load_value;
    wire [3:0]  flg = {zero_flag, carry_flag, half_carry_flag,
                       signed_range_flag};
    integer     err_count = 0;
    integer     checked = 0;
    integer     lat;
    reg         got_err;
    reg  [7:0]  ac = 8'h00;
    reg  [3:0]  fl = 4'h0;

    always #12.5 clk = ~clk;

    dtu_core dut
    (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_imm(cmd_imm), .cmd_ready(cmd_ready),
        .cmd_done(cmd_done), .cmd_err(cmd_err), .acc_out(acc_out),
        .zero_flag(zero_flag), .carry_flag(carry_flag),
        .half_carry_flag(half_carry_flag),
        .signed_range_flag(signed_range_flag), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
        .io_rdata(io_rdata), .timer_count(timer_count),
        .timer_load(timer_load), .timer_load_value(timer_load_value)
    );

    dtu_far far
    (
        .clk(clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
        .io_re(io_re), .io_rdata(io_rdata), .timer_count(timer_count),
        .timer_load(timer_load), .timer_load_value(timer_load_value)
    );

    // counts, verdict and end of run, shared with the hang guard
    task conclude;
    begin
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    // offer for one cycle only: holding valid would re-issue at done
    task cmd(input [3:0] op, input [7:0] ad, input [7:0] im);
    begin
        @(posedge clk);
        #1;
        `CHK(cmd_ready, 1'b1)
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = ad;
        cmd_imm = im;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        lat = 0;
        while (cmd_done !== 1'b1 && lat < 20)
        begin
            @(posedge clk);
            #1;
            lat = lat + 1;
        end
        if (lat == 20)
        begin
            err_count = err_count + 1;
            $display("unexpected at %0t: no done", $time);
            conclude;
        end
        got_err = cmd_err;
    end
    endtask

    // one accepted command with expected accumulator, flags and length
    task step(input [3:0] op, input [7:0] ad, input [7:0] im,
              input [7:0] ea, input [3:0] ef, input [2:0] el);
    begin
        cmd(op, ad, im);
        `CHK(acc_out, ea)
        `CHK(flg, ef)
        `CHK(lat[2:0], el)
        `CHK(got_err, 1'b0)
        ac = ea;
        fl = ef;
    end
    endtask

    task mvi(input [7:0] v);
        step(4'h0, 8'h00, v, v, fl, 3'h2);
    endtask

    task sta(input [7:0] ad);
        step(4'h1, ad, 8'h00, ac, fl, 3'h2);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        `CHK(acc_out, 8'h00)
        `CHK(flg, 4'h0)
        // flag arithmetic, flags ordered zero, carry, half, signed
        mvi(8'h88);
        step(4'h9, 8'h00, 8'h88, 8'h10, 4'h7, 3'h2);
        step(4'h9, 8'h00, 8'hF0, 8'h00, 4'hC, 3'h2);
        mvi(8'h80);
        step(4'hA, 8'h00, 8'h01, 8'h7F, 4'h3, 3'h2);
        step(4'hA, 8'h00, 8'h80, 8'hFF, 4'h5, 3'h2);
        $display("test alu flags done");
        sta(8'h10);
        mvi(8'h00);
        sta(8'h11);
        step(4'h2, 8'h10, 8'h00, 8'hFF, 4'h5, 3'h2);
        step(4'h2, 8'h11, 8'h00, 8'h00, 4'hD, 3'h2);
        $display("test memory moves done");
        mvi(8'hC3);
        step(4'h4, 8'h21, 8'h00, 8'hC3, 4'hD, 3'h2);
        mvi(8'h00);
        step(4'h3, 8'h21, 8'h00, 8'hC3, 4'h5, 3'h2);
        step(4'h3, 8'h5A, 8'h00, 8'h00, 4'hD, 3'h2);
        $display("test io moves done");
        mvi(8'h34);
        sta(8'h20);
        mvi(8'h12);
        sta(8'h21);
        step(4'h6, 8'h20, 8'h00, 8'h12, 4'hD, 3'h2);
        `CHK(timer_count, 16'h1234)
        mvi(8'h00);
        step(4'h5, 8'h30, 8'h00, 8'h00, 4'hD, 3'h2);
        step(4'h2, 8'h30, 8'h00, 8'h34, 4'h5, 3'h2);
        step(4'h2, 8'h31, 8'h00, 8'h12, 4'h5, 3'h2);
        $display("test timer words done");
        mvi(8'h5B);
        sta(8'h40);
        mvi(8'h00);
        sta(8'h41);
        mvi(8'hA5);
        step(4'h8, 8'h40, 8'h00, 8'hA5, 4'h5, 3'h4);
        mvi(8'h00);
        step(4'h7, 8'h40, 8'h00, 8'hA5, 4'h5, 3'h4);
        step(4'h2, 8'h5B, 8'h00, 8'hA5, 4'h5, 3'h2);
        $display("test indirect moves done");
        mvi(8'h00);
        sta(8'h3F);
        step(4'hD, 8'h3F, 8'h07, 8'h00, 4'h5, 3'h2);
        step(4'h2, 8'h3F, 8'h00, 8'h80, 4'h5, 3'h2);
        step(4'hE, 8'h3F, 8'h07, 8'h80, 4'h5, 3'h2);
        step(4'h2, 8'h3F, 8'h00, 8'h00, 4'hD, 3'h2);
        cmd(4'hD, 8'h40, 8'h07);
        `CHK(got_err, 1'b1)
        `CHK(lat[2:0], 3'h0)
        step(4'h2, 8'h40, 8'h00, 8'h5B, 4'h5, 3'h2);
        step(4'hB, 8'h5B, 8'h00, 8'h00, 4'hE, 3'h2);
        step(4'hC, 8'h5B, 8'h00, 8'h5B, 4'h6, 3'h2);
        cmd(4'hF, 8'h00, 8'h00);
        `CHK(got_err, 1'b1)
        $display("test bit limits done");
        conclude;
    end
endmodule // dtu_core_bench
